// ---- hw/sci_defs.vh ----
// sci_defs.vh: constants for the system-control instruction execution block
// assumes: included by the design, the checker and the bench; no processes here
`ifndef SCI_DEFS_VH
`define SCI_DEFS_VH
// widths
`define SCI_PC_W         12
`define SCI_SP_W         8
`define SCI_DW           8
// operation codes presented on i_op
`define SCI_OP_W         4
`define SCI_OP_IDLE      4'h0
`define SCI_OP_JUMP      4'h1
`define SCI_OP_INVOKE    4'h2
`define SCI_OP_BACK_IMM  4'h3
`define SCI_OP_BACK      4'h4
`define SCI_OP_LEAVE_ISR 4'h5
`define SCI_OP_CJUMP     4'h6
`define SCI_OP_IRQ_ON    4'h7
`define SCI_OP_IRQ_OFF   4'h8
`define SCI_OP_FULL_HALT 4'h9
`define SCI_OP_CORE_HALT 4'ha
`define SCI_OP_RESET     4'hb
`define SCI_OP_WD_CLEAR  4'hc
// stack pointer step per saved return address
`define SCI_SP_STEP      8'h02
// reset values
`define SCI_PC_RST       12'h000
`define SCI_SP_RST       8'h00
`define SCI_ACC_RST      8'h00
`define SCI_FLAGS_RST    4'h0
`define SCI_GIE_RST      1'b0
`define SCI_RDY_RST      1'b1
`define SCI_OSC_RST      1'b1
`define SCI_CLKEN_RST    1'b1
// flag field positions in o_flags
`define SCI_FLAG_Z       0
`define SCI_FLAG_C       1
`define SCI_FLAG_AC      2
`define SCI_FLAG_OV      3
`endif

// ---- hw/sci_exec.v ----
// sci_exec.v: execution of the system-control instruction group
// assumes: i_op_valid is seen only while o_ready is high; the stack memory
// answers a read in the same cycle (combinational i_stk_rdata for o_stk_addr);
// o_chip_rst is meant to drive the chip reset back into i_rst_n, and until
// that reset arrives the core stays halted and ignores the wake line
`timescale 1ns/1ps
`include "sci_defs.vh"

module sci_exec (
	input  wire                  i_ref_clk,    // core system clock, 50 MHz
	input  wire                  i_rst_n,      // synchronous reset, active low
	input  wire                  i_op_valid,   // instruction present this cycle
	input  wire [`SCI_OP_W-1:0]  i_op,         // decoded system-control operation
	input  wire [`SCI_PC_W-1:0]  i_target,     // jump / invoke target address
	input  wire [`SCI_DW-1:0]    i_imm,        // immediate for return with value
	input  wire [`SCI_PC_W-1:0]  i_stk_rdata,  // stack slot contents at o_stk_addr
	input  wire                  i_wake,       // wake-up event ends a core or full halt, not the soft-reset halt
	input  wire [3:0]            i_flags_in,   // flags from the arithmetic unit
	input  wire                  i_flags_we,   // arithmetic unit writes flags
	input  wire [`SCI_DW-1:0]    i_acc_in,     // work register a from other units
	input  wire                  i_acc_we,     // other units write work register a
	output reg                   o_ready,      // accepts an instruction this cycle
	output reg  [`SCI_PC_W-1:0]  o_pc,         // instruction counter
	output reg  [`SCI_SP_W-1:0]  o_sp,         // stack top pointer
	output reg  [`SCI_DW-1:0]    o_acc,        // work register a
	output reg  [3:0]            o_flags,      // z, c, ac, ov
	output reg                   o_gie,        // global interrupt enable
	output reg  [`SCI_SP_W-1:0]  o_stk_addr,   // stack slot address
	output reg  [`SCI_PC_W-1:0]  o_stk_wdata,  // return address to store
	output reg                   o_stk_we,     // stack write strobe, one cycle
	output reg                   o_osc_run,    // oscillators enabled
	output reg                   o_sysclk_en,  // system clock gate enable
	output reg                   o_chip_rst,   // chip-wide soft reset pulse
	output reg                   o_wdt_clr     // watchdog restart pulse
);

	////////////////////////////////////////////////////////////////////////
	localparam ST_RUN  = 2'b00;
	localparam ST_WAIT = 2'b01;
	localparam ST_HALT = 2'b10;

	reg  [1:0]             state;
	reg  [1:0]             next_state;
	reg  [`SCI_PC_W-1:0]   next_pc;
	reg  [`SCI_SP_W-1:0]   next_sp;
	reg  [`SCI_DW-1:0]     next_acc;
	reg                    next_gie;
	reg                    next_ready;
	reg  [`SCI_SP_W-1:0]   next_stk_addr;
	reg  [`SCI_PC_W-1:0]   next_stk_wdata;
	reg                    next_stk_we;
	reg                    next_osc_run;
	reg                    next_sysclk_en;
	reg                    next_chip_rst;
	reg                    next_wdt_clr;
	reg                    ret_pend;
	reg                    next_ret_pend;
	reg                    ret_gie;
	reg                    next_ret_gie;
	reg                    soft_rst_hold;       // soft reset issued, waiting for chip reset
	reg                    next_soft_rst_hold;

	function [`SCI_PC_W-1:0] pc_inc;
		input [`SCI_PC_W-1:0] pc;
		begin
			pc_inc = pc + {{(`SCI_PC_W-1){1'b0}}, 1'b1};
		end
	endfunction

	// the stack pointer wraps silently: nesting deeper than the stack overwrites slots
	function [`SCI_SP_W-1:0] sp_push;
		input [`SCI_SP_W-1:0] sp;
		begin
			sp_push = sp + `SCI_SP_STEP;
		end
	endfunction

	function [`SCI_SP_W-1:0] sp_pop;
		input [`SCI_SP_W-1:0] sp;
		begin
			sp_pop = sp - `SCI_SP_STEP;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	always @* begin
		next_state     = state;
		next_pc        = o_pc;
		next_sp        = o_sp;
		next_acc       = i_acc_we ? i_acc_in : o_acc;
		next_gie       = o_gie;
		next_ready     = o_ready;
		next_stk_addr  = o_stk_addr;
		next_stk_wdata = o_stk_wdata;
		next_stk_we    = 1'b0;
		next_osc_run   = o_osc_run;
		next_sysclk_en = o_sysclk_en;
		next_chip_rst  = 1'b0;
		next_wdt_clr   = 1'b0;
		next_ret_pend  = 1'b0;
		next_ret_gie   = 1'b0;
		next_soft_rst_hold = soft_rst_hold;
		case (state)
		ST_RUN: begin
			// an instruction offered while not ready is dropped without notice
			if (i_op_valid && o_ready) begin
				case (i_op)
				`SCI_OP_JUMP: begin
					next_pc    = i_target;
					next_ready = 1'b0;
					next_state = ST_WAIT;
				end
				`SCI_OP_INVOKE: begin
					next_stk_addr  = o_sp;
					next_stk_wdata = pc_inc(o_pc);
					next_stk_we    = 1'b1;
					next_sp        = sp_push(o_sp);
					next_pc        = i_target;
					next_ready     = 1'b0;
					next_state     = ST_WAIT;
				end
				`SCI_OP_BACK_IMM, `SCI_OP_BACK, `SCI_OP_LEAVE_ISR: begin
					if (i_op == `SCI_OP_BACK_IMM)
						next_acc = i_imm;
					next_sp       = sp_pop(o_sp);
					next_stk_addr = sp_pop(o_sp);
					next_ret_pend = 1'b1;
					next_ret_gie  = (i_op == `SCI_OP_LEAVE_ISR);
					next_ready    = 1'b0;
					next_state    = ST_WAIT;
				end
				`SCI_OP_CJUMP: begin
					next_pc    = o_pc + {{(`SCI_PC_W-`SCI_DW){1'b0}}, o_acc};
					next_ready = 1'b0;
					next_state = ST_WAIT;
				end
				`SCI_OP_IRQ_ON: begin
					next_gie = 1'b1;
					next_pc  = pc_inc(o_pc);
				end
				`SCI_OP_IRQ_OFF: begin
					next_gie = 1'b0;
					next_pc  = pc_inc(o_pc);
				end
				`SCI_OP_FULL_HALT: begin
					next_osc_run   = 1'b0;
					next_sysclk_en = 1'b0;
					next_ready     = 1'b0;
					next_pc        = pc_inc(o_pc);
					next_state     = ST_HALT;
				end
				`SCI_OP_CORE_HALT: begin
					next_sysclk_en = 1'b0;
					next_ready     = 1'b0;
					next_pc        = pc_inc(o_pc);
					next_state     = ST_HALT;
				end
				`SCI_OP_RESET: begin
					// the pulse is fed back to the chip reset, which clears this block too
					next_chip_rst = 1'b1;
					next_soft_rst_hold = 1'b1;
					next_ready    = 1'b0;
					next_state    = ST_HALT;
				end
				`SCI_OP_WD_CLEAR: begin
					next_wdt_clr = 1'b1;
					next_pc      = pc_inc(o_pc);
				end
				default: begin
					// codes outside the table behave as the idle instruction
					next_pc = pc_inc(o_pc);
				end
				endcase
			end
		end
		ST_WAIT: begin
			// second instruction cycle: stack slot now addressed
			if (ret_pend) begin
				next_pc = i_stk_rdata;
				if (ret_gie)
					next_gie = 1'b1;
			end
			next_ready = 1'b1;
			next_state = ST_RUN;
		end
		ST_HALT: begin
			// halted core only sees the wake line; soft reset waits for chip reset,
			// since waking there would run the reset instruction once more
			if (i_wake && !soft_rst_hold) begin
				next_osc_run   = 1'b1;
				next_sysclk_en = 1'b1;
				next_ready     = 1'b1;
				next_state     = ST_RUN;
			end
		end
		default: begin
			next_state = ST_RUN;
			next_ready = 1'b1;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// sequencing: state, handshake and the return bookkeeping
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			state         <= ST_RUN;
			o_ready       <= `SCI_RDY_RST;
			ret_pend      <= 1'b0;
			ret_gie       <= 1'b0;
			soft_rst_hold <= 1'b0;
		end else begin
			state         <= next_state;
			o_ready       <= next_ready;
			ret_pend      <= next_ret_pend;
			ret_gie       <= next_ret_gie;
			soft_rst_hold <= next_soft_rst_hold;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// program flow
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_pc <= `SCI_PC_RST;
		end else begin
			o_pc <= next_pc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// stack pointer and stack port; the write strobe lasts one cycle
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_sp        <= `SCI_SP_RST;
			o_stk_addr  <= `SCI_SP_RST;
			o_stk_wdata <= `SCI_PC_RST;
			o_stk_we    <= 1'b0;
		end else begin
			o_sp        <= next_sp;
			o_stk_addr  <= next_stk_addr;
			o_stk_wdata <= next_stk_wdata;
			o_stk_we    <= next_stk_we;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// work register a: the immediate return wins over another unit's write
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_acc <= `SCI_ACC_RST;
		end else begin
			o_acc <= next_acc;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// flags follow only the arithmetic unit, never this group
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_flags <= `SCI_FLAGS_RST;
		end else if (i_flags_we) begin
			o_flags <= i_flags_in;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt enable, clock gating and the one-cycle pulses;
	// the gating outputs are levels held until a wake
	always @(posedge i_ref_clk) begin
		if (!i_rst_n) begin
			o_gie       <= `SCI_GIE_RST;
			o_osc_run   <= `SCI_OSC_RST;
			o_sysclk_en <= `SCI_CLKEN_RST;
			o_chip_rst  <= 1'b0;
			o_wdt_clr   <= 1'b0;
		end else begin
			o_gie       <= next_gie;
			o_osc_run   <= next_osc_run;
			o_sysclk_en <= next_sysclk_en;
			o_chip_rst  <= next_chip_rst;
			o_wdt_clr   <= next_wdt_clr;
		end
	end

endmodule // sci_exec

// ---- tb/sci_exec_asserts.sv ----
// sci_exec_asserts.sv: port-level checker for the system-control execution block
// assumes: bound to sci_exec; one clock, sync active-low reset
`timescale 1ns/1ps
`include "sci_defs.vh"
module sci_exec_asserts (
	input wire        i_ref_clk,   // clock
	input wire        i_rst_n,     // reset
	input wire        i_op_valid,  // request
	input wire [3:0]  i_op,        // op code
	input wire [11:0] i_target,    // target
	input wire [7:0]  i_imm,       // return value
	input wire        i_flags_we,  // flag write
	input wire        o_ready,     // accept
	input wire [11:0] o_pc,        // counter
	input wire [7:0]  o_sp,        // stack top
	input wire [7:0]  o_acc,       // work reg a
	input wire [3:0]  o_flags,     // flags
	input wire        o_gie,       // irq enable
	input wire        o_stk_we,    // stack write
	input wire        o_osc_run,   // osc on
	input wire        o_sysclk_en, // clock gate
	input wire        o_chip_rst,  // soft reset
	input wire        o_wdt_clr    // wd restart
);
////////////////////////////////////////
default clocking @(posedge i_ref_clk); endclocking
default disable iff (!i_rst_n);
// set once a soft reset has been issued; only the chip reset clears it
reg rst_seen;
always @(posedge i_ref_clk) begin
	if (!i_rst_n) rst_seen <= 1'b0;
	else if (o_chip_rst) rst_seen <= 1'b1;
end
// one-hot of the op taken at this edge; codes 1..6 form the two-cycle group
wire [15:0] dec = {15'h0000, i_op_valid & o_ready} << i_op;
a_invoke_push: assert property (dec[`SCI_OP_INVOKE] |=> o_pc == $past(i_target) && o_stk_we
	&& o_sp == $past(o_sp) + `SCI_SP_STEP) else $error("invoke push wrong");
a_jump_nosave: assert property (dec[`SCI_OP_JUMP] |=> o_pc == $past(i_target) && !o_stk_we
	&& $stable(o_sp)) else $error("jump wrong");
a_back_pop: assert property (dec[`SCI_OP_BACK] |=> o_sp == $past(o_sp) - `SCI_SP_STEP) else $error("pop wrong");
a_imm_load: assert property (dec[`SCI_OP_BACK_IMM] |=> o_acc == $past(i_imm))
	else $error("return value wrong");
a_isr_gie: assert property (dec[`SCI_OP_LEAVE_ISR] |-> ##2 o_gie) else $error("isr return gie");
a_cjump_sum: assert property (dec[`SCI_OP_CJUMP] |=> o_pc == $past(o_pc) + {4'h0, $past(o_acc)})
	else $error("computed jump wrong");
a_gie_set: assert property (dec[`SCI_OP_IRQ_ON] |=> o_gie) else $error("gie not set");
a_gie_clear: assert property (dec[`SCI_OP_IRQ_OFF] |=> !o_gie) else $error("gie not cleared");
a_full_stop: assert property (dec[`SCI_OP_FULL_HALT] |=> !o_osc_run && !o_sysclk_en) else $error("full halt");
a_core_stop: assert property (dec[`SCI_OP_CORE_HALT] |=> o_osc_run && !o_sysclk_en) else $error("core halt");
a_soft_reset: assert property (dec[`SCI_OP_RESET] |=> o_chip_rst) else $error("no chip reset");
a_reset_stays: assert property (rst_seen |-> !o_ready) else $error("left soft reset halt");
a_wdt_pulse: assert property (o_wdt_clr == $past(dec[`SCI_OP_WD_CLEAR])) else $error("wd pulse");
a_flags_hold: assert property (!i_flags_we |=> $stable(o_flags)) else $error("flags changed");
a_two_cycle: assert property (|dec[6:1] |=> !o_ready ##1 o_ready) else $error("two-cycle timing");
a_idle_step: assert property (dec[`SCI_OP_IDLE] |=> o_pc == $past(o_pc) + 12'h001 && $stable(o_sp))
	else $error("idle step wrong");
c_invoke: cover property (dec[`SCI_OP_INVOKE]);
c_isr: cover property (dec[`SCI_OP_LEAVE_ISR]);
c_wake: cover property (dec[`SCI_OP_CORE_HALT] ##[1:5] o_ready);
c_refused: cover property (i_op_valid && !o_ready);
endmodule // sci_exec_asserts
bind sci_exec sci_exec_asserts sci_exec_asserts_i (
	.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid), .i_op(i_op),
	.i_target(i_target), .i_imm(i_imm), .i_flags_we(i_flags_we), .o_ready(o_ready), .o_pc(o_pc),
	.o_sp(o_sp), .o_acc(o_acc), .o_flags(o_flags), .o_gie(o_gie), .o_stk_we(o_stk_we),
	.o_osc_run(o_osc_run), .o_sysclk_en(o_sysclk_en), .o_chip_rst(o_chip_rst), .o_wdt_clr(o_wdt_clr)
);

// ---- tb/sci_exec_tb.sv ----
// sci_exec_tb.sv: directed bench for the system-control execution block
// assumes: design and checker compiled first; stack memory modelled here
`timescale 1ns/1ps
`include "sci_defs.vh"
module sci_exec_tb;
	reg         clk = 0, rst_n = 0, vld = 0, wake = 0, fwe = 0, awe = 0, p_we, p_wdt, p_rst;
	reg  [3:0]  op = 0, fin = 0;
	reg  [11:0] tgt = 0;
	reg  [7:0]  ain = 0;
	reg  [11:0] stk [0:255];
	wire [11:0] pc, wd;
	wire [7:0]  sp, acc, sa;
	wire [3:0]  flg;
	wire        rdy, gie, we, osc, sen, crst, wdt;
	integer     n_fail = 0, n_checks = 0, cyc = 0;
	////////////////////////////////////////
	initial forever #10 clk = ~clk;
	always @(posedge clk) if (we) stk[sa] <= wd;
	sci_exec sci_exec_i (.i_ref_clk(clk), .i_rst_n(rst_n), .i_op_valid(vld), .i_op(op), .i_target(tgt),
		.i_imm(tgt[7:0]), .i_stk_rdata(stk[sa]), .i_wake(wake), .i_flags_in(fin), .i_flags_we(fwe),
		.i_acc_in(ain), .i_acc_we(awe), .o_ready(rdy), .o_pc(pc), .o_sp(sp), .o_acc(acc), .o_flags(flg),
		.o_gie(gie), .o_stk_addr(sa), .o_stk_wdata(wd), .o_stk_we(we), .o_osc_run(osc),
		.o_sysclk_en(sen), .o_chip_rst(crst), .o_wdt_clr(wdt));
	task chk(input [15:0] g, input [15:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
			end
		end
	endtask
	// one instruction, pulses caught in cycle 1, state seen in cycle 2
	task issue(input [3:0] c, input [11:0] t);
		begin
			@(negedge clk); vld = 1; op = c; tgt = t;
			@(negedge clk); vld = 0; p_we = we; p_wdt = wdt; p_rst = crst;
			@(negedge clk);
		end
	endtask
	// two-cycle instruction with valid held into its busy cycle: the second op must be dropped
	task issue_held(input [3:0] c, input [3:0] c2, input [11:0] t);
		begin
			@(negedge clk); vld = 1; op = c; tgt = t;
			@(negedge clk); op = c2;
			@(negedge clk); vld = 0;
		end
	endtask
	task wakeup;
		begin
			@(negedge clk); wake = 1;
			@(negedge clk); wake = 0;
		end
	endtask
	task t_calls;
		begin
			issue(`SCI_OP_INVOKE, 12'hffe); chk(pc, 16'h0ffe);
			chk({sp, 7'h00, p_we}, 16'h0201);
			chk({sa[3:0], wd}, 16'h0001);
			issue(`SCI_OP_INVOKE, 12'h123); chk(sp, 16'h0004);
			chk({sa[3:0], wd}, 16'h2fff);
			issue(`SCI_OP_BACK, 12'h000); chk({pc, sp[3:0]}, 16'hfff2);
			issue(`SCI_OP_BACK_IMM, 12'h055); chk(acc, 16'h0055);
			chk({pc, sp[3:0]}, 16'h0010);
		end
	endtask
	task t_irq;
		begin
			issue(`SCI_OP_IRQ_ON, 12'h000); chk(gie, 16'h0001);
			issue(`SCI_OP_IRQ_OFF, 12'h000); chk(gie, 16'h0000);
			issue_held(`SCI_OP_JUMP, `SCI_OP_IRQ_ON, 12'h800); chk({pc, sp[2:0], gie}, 16'h8000);
			issue(`SCI_OP_INVOKE, 12'h0aa);
			issue(`SCI_OP_LEAVE_ISR, 12'h000); chk({pc, 3'h0, gie}, 16'h8011);
		end
	endtask
	task t_misc;
		begin
			@(negedge clk); awe = 1; ain = 8'h10; fwe = 1; fin = 4'ha;
			@(negedge clk); awe = 0; fwe = 0;
			issue(`SCI_OP_CJUMP, 12'h000); chk(pc, 16'h0811);
			issue(`SCI_OP_IDLE, 12'h000); chk({pc, acc[7:4]}, 16'h8121);
			issue(`SCI_OP_WD_CLEAR, 12'h000); chk(p_wdt, 16'h0001);
			chk(flg, 16'h000a);
			issue(4'hf, 12'h000); chk(pc, 16'h0814);
		end
	endtask
	task t_halts;
		begin
			issue(`SCI_OP_CORE_HALT, 12'h000); chk({rdy, osc, sen}, 16'h0002);
			wakeup; chk({rdy, sen}, 16'h0003);
			issue(`SCI_OP_FULL_HALT, 12'h000); chk({osc, sen}, 16'h0000);
			wakeup; chk({osc, sen}, 16'h0003);
			issue(`SCI_OP_RESET, 12'h000); chk(p_rst, 16'h0001);
			wakeup; chk(rdy, 16'h0000);
			@(negedge clk); rst_n = 0;
			@(negedge clk); rst_n = 1; chk({rdy, pc, sp[2:0]}, 16'h8000);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", n_checks, n_fail);
			if (n_fail == 0 && n_checks > 0) $display("Run complete: PASS");
			else $display("Run complete: FAIL");
			$finish;
		end
	endtask
	// generous ceiling: the sequence needs well under 200 cycles
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 3000) begin
			n_fail = n_fail + 1;
			finish_test;
		end
	end
	initial begin
		repeat (2) @(negedge clk);
		rst_n = 1;
		t_calls;
		t_irq;
		t_misc;
		t_halts;
		finish_test;
	end
endmodule // sci_exec_tb
